// *** hdl/lock_pkg.sv ***
// constants and types shared by the code-lock and signature block
package lock_pkg;
   // ==========================================
   // storage and field widths
   localparam int BYTE_W = 8;
   localparam int ADDR_W = 16;
   localparam int ENC_SEL_W = 6;
   localparam int ENC_DEPTH = 64;
   localparam int LOCK_W = 3;
   localparam int CMD_W = 3;
   localparam logic [7:0] ERASED_BYTE = 8'hff;
   localparam logic [2:0] LOCK_ERASED = 3'h7;
   // ==========================================
   // register byte offsets on the bus
   localparam logic [7:0] ADDR_OFS = 8'h00;
   localparam logic [7:0] DATA_OFS = 8'h04;
   localparam logic [7:0] CMD_OFS = 8'h08;
   localparam logic [7:0] RESULT_OFS = 8'h0c;
   localparam logic [7:0] STATUS_OFS = 8'h10;
   // ==========================================
   // field positions
   localparam int RES_REFUSED_BIT = 8;
   localparam int STAT_LEVEL_LSB = 0;
   localparam int STAT_LOCK_LSB = 2;
   localparam int STAT_EA_BIT = 5;
   localparam int STAT_EXT_BIT = 6;
   // lock bit index selectors held in the data register
   localparam logic [1:0] SEL_LOCK_ONE = 2'h1;
   localparam logic [1:0] SEL_LOCK_TWO = 2'h2;
   localparam logic [1:0] SEL_LOCK_THREE = 2'h3;
   // ==========================================
   // signature locations
   localparam logic [7:0] SIG_LOC0 = 8'h30;
   localparam logic [7:0] SIG_LOC1 = 8'h31;
   localparam logic [7:0] SIG_LOC2 = 8'h60;
   // ==========================================
   // commands and protection levels
   typedef enum logic [2:0] {
      CMD_NONE,
      CMD_PROG_CODE,
      CMD_PROG_ENC,
      CMD_PROG_LOCK,
      CMD_ERASE,
      CMD_VERIFY,
      CMD_SIGNATURE
   } cmd_t;
   typedef enum logic [1:0] {
      LEVEL_OPEN,
      LEVEL_FETCH_LOCK,
      LEVEL_VERIFY_LOCK,
      LEVEL_FULL_LOCK
   } level_t;
endpackage

// *** hdl/verify_byte_path.sv ***
// verify and signature read data path
`timescale 1ns/1ps
`default_nettype none
module verify_byte_path
#(
   parameter logic [7:0] SIG_BYTE0 = 8'ha5,
   parameter logic [7:0] SIG_BYTE1 = 8'h3c,
   parameter logic [7:0] SIG_BYTE2 = 8'h0f
)
(
   input wire logic [7:0] sig_addr,
   input wire logic [7:0] code_byte,
   input wire logic [7:0] enc_byte,
   input wire lock_pkg::level_t level,
   output logic [7:0] verify_byte,
   output logic verify_blocked,
   output logic [7:0] sig_byte
);
   import lock_pkg::*;
   // ==========================================
   // verify: code byte xnor encryption byte, blocked from level three up
   always_comb
   begin
      verify_blocked = (level == LEVEL_VERIFY_LOCK) || (level == LEVEL_FULL_LOCK);
      if (verify_blocked)
      begin
         verify_byte = ERASED_BYTE;
      end
      else
      begin
         verify_byte = ~(code_byte ^ enc_byte);
      end
   end
   // ==========================================
   // fixed signature bytes, other locations read as erased
   always_comb
   begin
      case (sig_addr)
         SIG_LOC0: sig_byte = SIG_BYTE0;
         SIG_LOC1: sig_byte = SIG_BYTE1;
         SIG_LOC2: sig_byte = SIG_BYTE2;
         default: sig_byte = ERASED_BYTE;
      endcase
   end
endmodule
`default_nettype wire

// *** hdl/code_lock_and_signature_read.sv ***
// code store protection, lock decode and signature read behind an apb slave
//
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module code_lock_and_signature_read
#(
   parameter int CODE_AW = 8,
   parameter logic [7:0] SIG_BYTE0 = 8'ha5, // arbitrary identification value
   parameter logic [7:0] SIG_BYTE1 = 8'h3c, // arbitrary identification value
   parameter logic [7:0] SIG_BYTE2 = 8'h0f // arbitrary identification value
)
(
   input wire logic clock,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic external_access_pin,
   input wire logic fetch_valid,
   input wire logic [CODE_AW-1:0] fetch_addr,
   input wire logic fetch_from_external,
   input wire logic code_table_fetch_instruction,
   output logic [7:0] fetch_data,
   output logic fetch_denied,
   output logic fetch_done,
   output logic external_access_effective,
   output logic external_exec_enable
);
   import lock_pkg::*;
   localparam int CODE_DEPTH = 1 << CODE_AW;

   // ==========================================
   // storage, kept through srst like the nonvolatile array it models
   logic [7:0] code_r [CODE_DEPTH];
   logic [7:0] code_nxt [CODE_DEPTH];
   logic [7:0] enc_r [ENC_DEPTH];
   logic [7:0] enc_nxt [ENC_DEPTH];
   logic [2:0] lock_r;
   logic [2:0] lock_nxt;
   // control state
   logic [15:0] addr_r, addr_nxt;
   logic [7:0] data_r, data_nxt;
   logic [7:0] result_r, result_nxt;
   logic refused_r, refused_nxt;
   level_t level_r, level_nxt;
   logic ea_r, ea_nxt;
   logic ext_r, ext_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic err_r, err_nxt;
   logic [7:0] fdata_r, fdata_nxt;
   logic fdenied_r, fdenied_nxt;
   logic fdone_r, fdone_nxt;
   // decoded strobes
   logic wr_en, setup_en, prog_code, prog_enc, erase_now, table_block;
   logic [CODE_AW-1:0] code_idx;
   logic [ENC_SEL_W-1:0] enc_idx;
   logic [7:0] cur_code, cur_enc, verify_byte, sig_byte;
   logic verify_blocked;
   cmd_t cmd;

   // most restrictive level implied by whichever bits are programmed (zero)
   function automatic level_t decode_level(input logic [2:0] lb);
      level_t lv;
      if (!lb[2])
         lv = LEVEL_FULL_LOCK;
      else if (!lb[1])
         lv = LEVEL_VERIFY_LOCK;
      else if (!lb[0])
         lv = LEVEL_FETCH_LOCK;
      else
         lv = LEVEL_OPEN;
      return lv;
   endfunction

   // ==========================================
   // apb decode; zero wait states, read data captured in the setup cycle
   assign wr_en = psel && penable && pwrite;
   assign setup_en = psel && !penable;
   assign pready = psel && penable;
   assign cmd = cmd_t'(pwdata[CMD_W-1:0]);
   assign code_idx = addr_r[CODE_AW-1:0];
   assign enc_idx = addr_r[ENC_SEL_W-1:0];
   assign cur_code = code_r[code_idx];
   assign cur_enc = enc_r[enc_idx];

   verify_byte_path #(
      .SIG_BYTE0(SIG_BYTE0),
      .SIG_BYTE1(SIG_BYTE1),
      .SIG_BYTE2(SIG_BYTE2)
   ) u_path (
      .sig_addr(addr_r[7:0]),
      .code_byte(cur_code),
      .enc_byte(cur_enc),
      .level(level_r),
      .verify_byte(verify_byte),
      .verify_blocked(verify_blocked),
      .sig_byte(sig_byte)
   );

   // ==========================================
   // command execution and register writes
   always_comb
   begin
      addr_nxt = addr_r;
      data_nxt = data_r;
      result_nxt = result_r;
      refused_nxt = refused_r;
      lock_nxt = lock_r;
      prog_code = 1'b0;
      prog_enc = 1'b0;
      erase_now = 1'b0;
      if (wr_en)
      begin
         case (paddr)
            ADDR_OFS: addr_nxt = pwdata[ADDR_W-1:0];
            DATA_OFS: data_nxt = pwdata[BYTE_W-1:0];
            CMD_OFS:
            begin
               refused_nxt = 1'b0;
               case (cmd)
                  CMD_PROG_CODE:
                  begin
                     prog_code = (level_r == LEVEL_OPEN);
                     refused_nxt = (level_r != LEVEL_OPEN);
                  end
                  CMD_PROG_ENC:
                  begin
                     prog_enc = (level_r == LEVEL_OPEN);
                     refused_nxt = (level_r != LEVEL_OPEN);
                  end
                  CMD_PROG_LOCK:
                  begin
                     // each bit separately programmable, never back to one
                     case (data_r[1:0])
                        SEL_LOCK_ONE: lock_nxt[0] = 1'b0;
                        SEL_LOCK_TWO: lock_nxt[1] = 1'b0;
                        SEL_LOCK_THREE: lock_nxt[2] = 1'b0;
                        default: refused_nxt = 1'b1;
                     endcase
                  end
                  CMD_ERASE:
                  begin
                     erase_now = 1'b1;
                     lock_nxt = LOCK_ERASED;
                  end
                  CMD_VERIFY:
                  begin
                     result_nxt = verify_byte;
                     refused_nxt = verify_blocked;
                  end
                  CMD_SIGNATURE: result_nxt = sig_byte;
                  default: refused_nxt = 1'b1;
               endcase
            end
            default: ;
         endcase
      end
   end

   // lock bits hold through srst; only erase returns them to one
   always_ff @(posedge clock)
   begin
      lock_r <= lock_nxt;
   end

   // ==========================================
   // per-entry storage; programming only clears bits, as an eprom cell does
   genvar gi;
   generate
      for (gi = 0; gi < CODE_DEPTH; gi++)
      begin : g_code
         always_comb
         begin
            code_nxt[gi] = code_r[gi];
            if (erase_now)
               code_nxt[gi] = ERASED_BYTE;
            else if (prog_code && code_idx == CODE_AW'(gi))
               code_nxt[gi] = code_r[gi] & data_r;
         end
         always_ff @(posedge clock)
         begin
            code_r[gi] <= code_nxt[gi];
         end
      end
      for (gi = 0; gi < ENC_DEPTH; gi++)
      begin : g_enc
         always_comb
         begin
            enc_nxt[gi] = enc_r[gi];
            if (erase_now)
               enc_nxt[gi] = ERASED_BYTE;
            else if (prog_enc && enc_idx == ENC_SEL_W'(gi))
               enc_nxt[gi] = enc_r[gi] & data_r;
         end
         always_ff @(posedge clock)
         begin
            enc_r[gi] <= enc_nxt[gi];
         end
      end
   endgenerate

   // ==========================================
   // read mux, protection outputs and fetch port
   always_comb
   begin
      prdata_nxt = prdata_r;
      err_nxt = err_r;
      if (setup_en)
      begin
         prdata_nxt = '0;
         err_nxt = 1'b0;
         case (paddr)
            ADDR_OFS: prdata_nxt[ADDR_W-1:0] = addr_r;
            DATA_OFS: prdata_nxt[BYTE_W-1:0] = data_r;
            CMD_OFS: ;
            RESULT_OFS:
            begin
               prdata_nxt[BYTE_W-1:0] = result_r;
               prdata_nxt[RES_REFUSED_BIT] = refused_r;
            end
            STATUS_OFS:
            begin
               prdata_nxt[STAT_LEVEL_LSB +: 2] = level_r;
               prdata_nxt[STAT_LOCK_LSB +: LOCK_W] = lock_r;
               prdata_nxt[STAT_EA_BIT] = ea_r;
               prdata_nxt[STAT_EXT_BIT] = ext_r;
            end
            default: err_nxt = 1'b1;
         endcase
      end
      // level stays frozen between resets
      level_nxt = level_r;
      // once locked, the pin level caught at reset is kept
      ea_nxt = (level_r == LEVEL_OPEN) ? external_access_pin : ea_r;
      ext_nxt = (level_r != LEVEL_FULL_LOCK);
      table_block = code_table_fetch_instruction && fetch_from_external && (level_r != LEVEL_OPEN);
      fdone_nxt = fetch_valid;
      fdenied_nxt = fetch_valid && table_block;
      fdata_nxt = fdata_r;
      if (fetch_valid)
         fdata_nxt = table_block ? ERASED_BYTE : code_r[fetch_addr];
   end

   // control registers; srst re-decodes the lock bits and samples the pin
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         addr_r <= '0;
         data_r <= '0;
         result_r <= ERASED_BYTE;
         refused_r <= 1'b0;
         level_r <= decode_level(lock_r);
         ea_r <= external_access_pin;
         // decoded here too, so full lock never lets one cycle of external execution through
         ext_r <= (decode_level(lock_r) != LEVEL_FULL_LOCK);
         prdata_r <= '0;
         err_r <= 1'b0;
         fdata_r <= '0;
         fdenied_r <= 1'b0;
         fdone_r <= 1'b0;
      end
      else
      begin
         addr_r <= addr_nxt;
         data_r <= data_nxt;
         result_r <= result_nxt;
         refused_r <= refused_nxt;
         level_r <= level_nxt;
         ea_r <= ea_nxt;
         ext_r <= ext_nxt;
         prdata_r <= prdata_nxt;
         err_r <= err_nxt;
         fdata_r <= fdata_nxt;
         fdenied_r <= fdenied_nxt;
         fdone_r <= fdone_nxt;
      end
   end

   assign prdata = prdata_r;
   assign pslverr = err_r && psel && penable;
   assign fetch_data = fdata_r;
   assign fetch_denied = fdenied_r;
   assign fetch_done = fdone_r;
   assign external_access_effective = ea_r;
   assign external_exec_enable = ext_r;

   // ==========================================
   // checks
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (srst);

   erase_clears_a: assert property (erase_now |=> lock_r == LOCK_ERASED && cur_enc == ERASED_BYTE)
      else $error("erase left lock or encryption bits programmed");
   erased_reads_a: assert property (erase_now |=> cur_code == ERASED_BYTE)
      else $error("erased code byte not all ones");
   sig_byte_a: assert property (wr_en && paddr == CMD_OFS && cmd == CMD_SIGNATURE && addr_r[7:0] == SIG_LOC1
      |=> result_r == SIG_BYTE1)
      else $error("wrong signature byte returned");
   open_verify_a: assert property (wr_en && paddr == CMD_OFS && cmd == CMD_VERIFY && level_r == LEVEL_OPEN
      |=> !refused_r && result_r == ~($past(cur_code) ^ $past(cur_enc)))
      else $error("verify byte not code xnor encryption");
   fetch_block_a: assert property (fetch_valid && table_block
      |=> fetch_denied && fetch_done && fetch_data == ERASED_BYTE)
      else $error("locked table fetch read internal code");
   ea_hold_a: assert property (level_r != LEVEL_OPEN |=> $stable(external_access_effective))
      else $error("latched external access level changed");
   prog_refuse_a: assert property (wr_en && paddr == CMD_OFS && cmd == CMD_PROG_CODE && level_r != LEVEL_OPEN
      |=> refused_r && $stable(cur_code))
      else $error("locked code store accepted programming");
   verify_block_a: assert property (wr_en && paddr == CMD_OFS && cmd == CMD_VERIFY && verify_blocked
      |=> refused_r && result_r == ERASED_BYTE)
      else $error("verify not blocked at level three");
   ext_exec_a: assert property (level_r == LEVEL_FULL_LOCK |=> !external_exec_enable)
      else $error("external execution allowed under full lock");
   level_hold_a: assert property (srst == 1'b0 |=> $stable(level_r))
      else $error("protection level changed between resets");
endmodule
`default_nettype wire

// *** dv/programmer_model.sv ***
// programmer and fetch requester model on the apb and fetch ports
`timescale 1ns/1ps
`default_nettype none
module programmer_model
#(
   parameter int AW = 4
)
(
   input wire logic clock,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   output logic fetch_valid,
   output logic [AW-1:0] fetch_addr,
   output logic fetch_from_external,
   output logic code_table_fetch_instruction,
   input wire logic [7:0] fetch_data,
   input wire logic fetch_denied,
   input wire logic fetch_done
);
   import lock_pkg::*;
   // =====
   // idle levels at time zero
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      fetch_valid = 1'b0;
      fetch_addr = '0;
      fetch_from_external = 1'b0;
      code_table_fetch_instruction = 1'b0;
   end
   // =====
   // apb master, request held until pready is sampled high
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output logic err);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clock);
      penable <= 1'b1;
      do
         @(posedge clock);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      // released data flips so a stale word never looks valid
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~wd;
      @(posedge clock);
   endtask
   // address, data, command, then the result word
   task automatic op(input logic [15:0] a, input logic [7:0] d, input cmd_t c, output logic [31:0] res);
      logic e;
      xfer(1'b1, ADDR_OFS, {16'h0000, a}, res, e);
      xfer(1'b1, DATA_OFS, {24'h00_0000, d}, res, e);
      xfer(1'b1, CMD_OFS, {29'h0000_0000, c}, res, e);
      xfer(1'b0, RESULT_OFS, 32'h0000_0000, res, e);
   endtask
   // one fetch request, answer sampled one cycle after it is taken
   task automatic fetch(input logic [AW-1:0] a, input logic ext, input logic tbl, output logic [9:0] ans);
      fetch_valid <= 1'b1;
      fetch_addr <= a;
      fetch_from_external <= ext;
      code_table_fetch_instruction <= tbl;
      @(posedge clock);
      fetch_valid <= 1'b0;
      fetch_addr <= ~a;
      @(posedge clock);
      ans = {fetch_done, fetch_denied, fetch_data};
   endtask
endmodule
`default_nettype wire

// *** dv/testbench.sv ***
// self-checking bench for the code lock and signature block
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin checks_done++; if ((got) !== (exp)) begin errors++; \
 $display("FAIL %s expected %h seen %h", what, exp, got); end end
module testbench;
   import lock_pkg::*;
   localparam int AW = 4;
   localparam int LIMIT = 6000;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic external_access_pin = 1'b1;
   logic psel, penable, pwrite, pready, pslverr, fetch_valid, fetch_from_external;
   logic code_table_fetch_instruction, fetch_denied, fetch_done, ea_eff, ext_en, e;
   logic [7:0] paddr, fetch_data;
   logic [31:0] pwdata, prdata, res;
   logic [AW-1:0] fetch_addr;
   logic [9:0] ans;
   logic [7:0] sig_loc [4] = '{SIG_LOC0, SIG_LOC1, SIG_LOC2, 8'h32};
   logic [7:0] sig_exp [4] = '{8'ha5, 8'h3c, 8'h0f, ERASED_BYTE};
   int errors = 0;
   int checks_done = 0;
   int cycles = 0;
   code_lock_and_signature_read #(.CODE_AW(AW), .SIG_BYTE0(8'ha5), .SIG_BYTE1(8'h3c), .SIG_BYTE2(8'h0f)) uut (
      .clock(clock), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .external_access_pin(external_access_pin), .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
      .fetch_from_external(fetch_from_external), .code_table_fetch_instruction(code_table_fetch_instruction),
      .fetch_data(fetch_data), .fetch_denied(fetch_denied), .fetch_done(fetch_done),
      .external_access_effective(ea_eff), .external_exec_enable(ext_en));
   programmer_model #(.AW(AW)) prog (
      .clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .fetch_valid(fetch_valid),
      .fetch_addr(fetch_addr), .fetch_from_external(fetch_from_external),
      .code_table_fetch_instruction(code_table_fetch_instruction), .fetch_data(fetch_data),
      .fetch_denied(fetch_denied), .fetch_done(fetch_done));
   // =====
   // clock and hang guard
   always #12.5 clock = ~clock;
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == LIMIT)
      begin
         errors++;
         complete_run();
      end
   end
   task automatic complete_run();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // reset pulse, locks are only decoded here
   task automatic restart();
      srst <= 1'b1;
      repeat (2) @(posedge clock);
      srst <= 1'b0;
      @(posedge clock);
   endtask
   // status: ext enable, ea, live locks, level
   task automatic status(input logic [6:0] exp);
      prog.xfer(1'b0, STATUS_OFS, 32'h0000_0000, res, e);
      `CHK("status", exp, res[6:0])
   endtask
   task automatic verify(input logic [15:0] a, input logic [8:0] exp);
      prog.op(a, 8'h00, CMD_VERIFY, res);
      `CHK("verify", exp, res[8:0])
   endtask
   // =====
   // main sequence
   initial
   begin
      repeat (2) @(posedge clock);
      srst <= 1'b0;
      @(posedge clock);
      prog.op(16'h0000, 8'h00, CMD_ERASE, res);
      restart();
      status(7'h7c);
      verify(16'h0005, 9'h0ff);
      prog.op(16'h0005, 8'h5a, CMD_PROG_CODE, res);
      prog.op(16'h0005, 8'h0f, CMD_PROG_ENC, res);
      prog.op(16'h0006, 8'h33, CMD_PROG_ENC, res);
      verify(16'h0005, {1'b0, ~(8'h5a ^ 8'h0f)});
      verify(16'h0006, 9'h033);
      for (int i = 0; i < 4; i++)
      begin
         prog.op({8'h00, sig_loc[i]}, 8'h00, CMD_SIGNATURE, res);
         `CHK("signature", sig_exp[i], res[7:0])
      end
      prog.op(16'h0000, 8'h00, cmd_t'(3'h7), res);
      `CHK("cmd7 refused", 1'b1, res[RES_REFUSED_BIT])
      prog.op(16'h0000, 8'h00, CMD_PROG_LOCK, res);
      `CHK("lock select 0 refused", 1'b1, res[RES_REFUSED_BIT])
      prog.xfer(1'b0, CMD_OFS, 32'h0000_0000, res, e);
      `CHK("cmd reads 0", 32'h0000_0000, res)
      prog.xfer(1'b0, 8'h14, 32'h0000_0000, res, e);
      `CHK("unmapped", 33'h1_0000_0000, {e, res})
      external_access_pin <= 1'b0;
      repeat (2) @(posedge clock);
      status(7'h5c);
      external_access_pin <= 1'b1;
      prog.fetch(4'h5, 1'b1, 1'b1, ans);
      `CHK("fetch open", 10'h25a, ans)
      prog.op(16'h0000, {6'h00, SEL_LOCK_ONE}, CMD_PROG_LOCK, res);
      status(7'h78);
      restart();
      status(7'h79);
      external_access_pin <= 1'b0;
      repeat (2) @(posedge clock);
      status(7'h79);
      `CHK("ea latched", 1'b1, ea_eff)
      external_access_pin <= 1'b1;
      prog.fetch(4'h5, 1'b1, 1'b1, ans);
      `CHK("table fetch external", 10'h3ff, ans)
      prog.fetch(4'h5, 1'b0, 1'b1, ans);
      `CHK("table fetch internal", 10'h25a, ans)
      prog.op(16'h0006, 8'h00, CMD_PROG_CODE, res);
      `CHK("locked prog refused", 1'b1, res[RES_REFUSED_BIT])
      verify(16'h0006, 9'h033);
      verify(16'h0005, 9'h0aa);
      prog.op(16'h0000, {6'h00, SEL_LOCK_TWO}, CMD_PROG_LOCK, res);
      restart();
      status(7'h72);
      verify(16'h0005, 9'h1ff);
      prog.op(16'h0000, {6'h00, SEL_LOCK_THREE}, CMD_PROG_LOCK, res);
      restart();
      status(7'h23);
      `CHK("ext exec off", 1'b0, ext_en)
      prog.op(16'h0000, 8'h00, CMD_ERASE, res);
      status(7'h3f);
      restart();
      status(7'h7c);
      verify(16'h0005, 9'h0ff);
      verify(16'h0006, 9'h0ff);
      complete_run();
   end
endmodule
`default_nettype wire
